// ---- core/gacc_top.sv ----
// Digital counting logic of the coupling_data_unit angle channels
//
// Operation
// - Sixteen-stage up/down read counter per channel
// - Error phase sets direction; nulled error holds
// - Steps at 800, 6400 or 12800 pps
// - Each read counter step is 19.8 arcsec
// - Computer pulses from least stage, 39.6 arcsec
// - Counting resumes whenever the angle moves again
// - Coarse ladder in 2.81 degree steps
// - Coarse and fine selections from one counter
// - Five channels; role depends on mode
// - Signed command pulses accumulate in error counter
// - Error counter drives ladder as magnitude, sign
// - Coarse align: third stage toggles null gimbal error
// - Display use: error held until counted back
// - Zero command clears and blocks read counters
`timescale 1ns/1ps
module gacc_top #(
   parameter logic [15:0] SLOW_CYC = gacc_pkg::SLOW_CYC,
   parameter logic [15:0] MID_CYC = gacc_pkg::MID_CYC,
   parameter logic [15:0] FAST_CYC = gacc_pkg::FAST_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire gacc_pkg::gacc_sense_type [gacc_pkg::NUM_CH-1:0] sense,
   input wire logic counter_zero_cmd,
   input wire logic err_cnt_enable,
   input wire logic coarse_align,
   input wire logic [gacc_pkg::NUM_CH-1:0] cmd_plus,
   input wire logic [gacc_pkg::NUM_CH-1:0] cmd_minus,
   output logic [gacc_pkg::NUM_CH-1:0] ang_inc_ff,
   output logic [gacc_pkg::NUM_CH-1:0] ang_dec_ff,
   output logic [gacc_pkg::NUM_CH-1:0][gacc_pkg::RC_W-1:0] read_count_ff,
   output logic [gacc_pkg::NUM_CH-1:0][6:0] coarse_sel_ff,
   output logic [gacc_pkg::NUM_CH-1:0][gacc_pkg::FINE_W-1:0] fine_sel_ff,
   output gacc_pkg::gacc_ladder_type [gacc_pkg::NUM_CH-1:0] ladder_ff
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Period in cycles for the band the detector reports
   function automatic logic [15:0] gacc_period(input gacc_pkg::gacc_rate_type band);
      logic [15:0] per;
      per = FAST_CYC;
      case (band)
         gacc_pkg::RATE_SLOW: per = SLOW_CYC;
         gacc_pkg::RATE_MID: per = MID_CYC;
         default: per = FAST_CYC;
      endcase
      return per;
   endfunction : gacc_period

   // Magnitude of a two's complement error count
   function automatic logic [gacc_pkg::ERR_W-2:0] gacc_abs(input logic [gacc_pkg::ERR_W-1:0] v);
      logic [gacc_pkg::ERR_W-1:0] a;
      a = v[gacc_pkg::ERR_W-1] ? (~v + 15'h0001) : v;
      return a[gacc_pkg::ERR_W-2:0];
   endfunction : gacc_abs

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   gacc_pkg::gacc_sense_type [gacc_pkg::NUM_CH-1:0] sense_s1_ff;
   gacc_pkg::gacc_sense_type [gacc_pkg::NUM_CH-1:0] sense_s2_ff;
   logic [gacc_pkg::NUM_CH-1:0][15:0] div_ff;
   logic [gacc_pkg::NUM_CH-1:0][gacc_pkg::ERR_W-1:0] err_ff;
   logic [gacc_pkg::NUM_CH-1:0][15:0] nxt_div;
   logic [gacc_pkg::NUM_CH-1:0][gacc_pkg::RC_W-1:0] nxt_rc;
   logic [gacc_pkg::NUM_CH-1:0][gacc_pkg::ERR_W-1:0] nxt_err;
   logic [gacc_pkg::NUM_CH-1:0] nxt_inc;
   logic [gacc_pkg::NUM_CH-1:0] nxt_dec;
   logic [gacc_pkg::NUM_CH-1:0] step;
   logic [gacc_pkg::NUM_CH-1:0] third_tog;
   logic [gacc_pkg::NUM_CH-1:0] coarse_pull;
   logic coarse_mode;
   logic [gacc_pkg::NUM_CH-1:0][6:0] nxt_coarse_sel;
   logic [gacc_pkg::NUM_CH-1:0][gacc_pkg::FINE_W-1:0] nxt_fine_sel;
   gacc_pkg::gacc_ladder_type [gacc_pkg::NUM_CH-1:0] nxt_ladder;

   // ---------------------------------------------------------------
   // Next-state logic for all channels
   // ---------------------------------------------------------------
   always_comb begin
      logic [15:0] per;
      logic [gacc_pkg::ERR_W-1:0] e;
      per = FAST_CYC;
      e = gacc_pkg::ERR_RST;
      // Both discretes together; either alone leaves the counter as a display hold
      coarse_mode = err_cnt_enable && coarse_align;
      for (int c = 0; c < gacc_pkg::NUM_CH; c++) begin
         per = gacc_period(sense_s2_ff[c].band);
         step[c] = 1'b0;
         nxt_rc[c] = read_count_ff[c];
         nxt_inc[c] = 1'b0;
         nxt_dec[c] = 1'b0;
         // Rate divider; held cleared at null or under zeroing
         if (counter_zero_cmd || sense_s2_ff[c].nulled) begin
            nxt_div[c] = gacc_pkg::DIV_RST;
         end else if (div_ff[c] >= per - 16'h0001) begin
            // The >= catches a band change to a faster rate mid-count
            nxt_div[c] = gacc_pkg::DIV_RST;
            step[c] = 1'b1;
         end else begin
            nxt_div[c] = div_ff[c] + 16'h0001;
         end
         // One step is one least stage, 19.8 arcsec; wraps over a full turn
         if (counter_zero_cmd) begin
            nxt_rc[c] = gacc_pkg::RC_RST;
         end else if (step[c] && sense_s2_ff[c].count_down) begin
            nxt_rc[c] = read_count_ff[c] - 16'h0001;
            nxt_dec[c] = ~read_count_ff[c][0];
         end else if (step[c]) begin
            nxt_rc[c] = read_count_ff[c] + 16'h0001;
            nxt_inc[c] = read_count_ff[c][0];
         end
         third_tog[c] = step[c] && (nxt_rc[c][gacc_pkg::THIRD_STAGE]
            != read_count_ff[c][gacc_pkg::THIRD_STAGE]);
         // Only gimbal channels servo their error counter toward zero
         coarse_pull[c] = coarse_mode && (c < gacc_pkg::NUM_GIMBAL) && third_tog[c]
            && (err_ff[c] != gacc_pkg::ERR_RST);
         e = err_ff[c];
         // Opposite commands in one cycle cancel; counts wrap, no saturation
         if (err_cnt_enable && cmd_plus[c] && !cmd_minus[c]) begin
            e = e + 15'h0001;
         end else if (err_cnt_enable && cmd_minus[c] && !cmd_plus[c]) begin
            e = e - 15'h0001;
         end
         if (coarse_pull[c] && err_ff[c][gacc_pkg::ERR_W-1]) begin
            e = e + 15'h0001;
         end else if (coarse_pull[c]) begin
            e = e - 15'h0001;
         end
         nxt_err[c] = e;
         // Taken from the new counts so the ladders move at the same edge as the counters
         nxt_coarse_sel[c] = nxt_rc[c][gacc_pkg::RC_W-1:gacc_pkg::COARSE_LSB];
         nxt_fine_sel[c] = nxt_rc[c][gacc_pkg::FINE_W-1:0];
         nxt_ladder[c].negative = e[gacc_pkg::ERR_W-1];
         nxt_ladder[c].magnitude = gacc_abs(e);
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Detector lines are analog-side levels, so two flops before use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sense_s1_ff <= '0;
         sense_s2_ff <= '0;
         div_ff <= '0;
         err_ff <= '0;
         read_count_ff <= '0;
         coarse_sel_ff <= '0;
         fine_sel_ff <= '0;
         ladder_ff <= '0;
         ang_inc_ff <= '0;
         ang_dec_ff <= '0;
      end else begin
         sense_s1_ff <= sense;
         sense_s2_ff <= sense_s1_ff;
         div_ff <= nxt_div;
         err_ff <= nxt_err;
         read_count_ff <= nxt_rc;
         ang_inc_ff <= nxt_inc;
         ang_dec_ff <= nxt_dec;
         coarse_sel_ff <= nxt_coarse_sel;
         fine_sel_ff <= nxt_fine_sel;
         ladder_ff <= nxt_ladder;
      end
   end

   // ---------------------------------------------------------------
   // Checks, per channel
   // ---------------------------------------------------------------
   for (genvar g = 0; g < gacc_pkg::NUM_CH; g++) begin : g_chk
      chk_zero_clears: assert property (@(posedge clk) disable iff (rst)
         counter_zero_cmd |=> read_count_ff[g] == gacc_pkg::RC_RST && !ang_inc_ff[g]
            && !ang_dec_ff[g])
         else $error("read counter not cleared by zero command");
      chk_null_holds: assert property (@(posedge clk) disable iff (rst)
         sense_s2_ff[g].nulled && !counter_zero_cmd |=> $stable(read_count_ff[g]))
         else $error("read counter moved while nulled");
      chk_step_dir: assert property (@(posedge clk) disable iff (rst)
         step[g] && !counter_zero_cmd |=> read_count_ff[g] ==
            ($past(sense_s2_ff[g].count_down) ? $past(read_count_ff[g]) - 16'h0001
            : $past(read_count_ff[g]) + 16'h0001))
         else $error("read counter step wrong");
      chk_rate_period: assert property (@(posedge clk) disable iff (rst)
         step[g] |-> !sense_s2_ff[g].nulled && div_ff[g] >= gacc_period(sense_s2_ff[g].band) - 16'h0001
            && $past(div_ff[g]) == div_ff[g] - 16'h0001)
         else $error("step outside its rate period");
      chk_inc_pulse: assert property (@(posedge clk) disable iff (rst)
         ang_inc_ff[g] |-> read_count_ff[g][0] == 1'b0 && $past(step[g])
            && !$past(sense_s2_ff[g].count_down))
         else $error("increment pulse without carry out of least stage");
      chk_one_strobe: assert property (@(posedge clk) disable iff (rst)
         (ang_inc_ff[g] || ang_dec_ff[g]) |-> !(ang_inc_ff[g] && ang_dec_ff[g])
            ##1 (!ang_inc_ff[g] && !ang_dec_ff[g]))
         else $error("angle pulse longer than one cycle");
      chk_retain_err: assert property (@(posedge clk) disable iff (rst)
         !coarse_pull[g] && !(err_cnt_enable && (cmd_plus[g] ^ cmd_minus[g]))
            |=> $stable(err_ff[g]) ##1 ladder_ff[g].magnitude == gacc_abs(err_ff[g]))
         else $error("error counter drifted without input");
      chk_cmd_accum: assert property (@(posedge clk) disable iff (rst)
         err_cnt_enable && cmd_plus[g] && !cmd_minus[g] && !coarse_pull[g]
            |=> err_ff[g] == $past(err_ff[g]) + 15'h0001)
         else $error("plus command not accumulated");
      chk_coarse_pull: assert property (@(posedge clk) disable iff (rst)
         coarse_pull[g] && !cmd_plus[g] && !cmd_minus[g] && !err_ff[g][gacc_pkg::ERR_W-1]
            |=> err_ff[g] == $past(err_ff[g]) - 15'h0001)
         else $error("coarse align did not pull error toward zero");
      chk_ladder_sign: assert property (@(posedge clk) disable iff (rst)
         ##1 ladder_ff[g].negative == err_ff[g][gacc_pkg::ERR_W-1])
         else $error("ladder sign does not follow error count");
      chk_coarse_sel: assert property (@(posedge clk) disable iff (rst)
         ##1 coarse_sel_ff[g] == read_count_ff[g][gacc_pkg::RC_W-1:gacc_pkg::COARSE_LSB]
            && fine_sel_ff[g] == read_count_ff[g][gacc_pkg::FINE_W-1:0])
         else $error("ladder selections not taken from read counter");
   end
endmodule : gacc_top

// ---- core/gacc_pkg.sv ----
// Package of constants and carrier types for the gimbal angle counter block
package gacc_pkg;
   // ---------------------------------------------------------------
   // Channel layout
   // ---------------------------------------------------------------
   localparam int NUM_CH = 5;
   localparam int NUM_GIMBAL = 3;
   localparam int RC_W = 16;
   localparam int ERR_W = 15;
   localparam int COARSE_LSB = 9;
   localparam int FINE_W = 11;
   localparam int THIRD_STAGE = 2;

   // ---------------------------------------------------------------
   // Scaling, tenths of an arc second
   // ---------------------------------------------------------------
   localparam int STEP_ARCSEC_X10 = 198;
   localparam int PULSE_ARCSEC_X10 = 396;
   localparam int CMD_ARCSEC_X10 = 1582;

   // ---------------------------------------------------------------
   // Stepping rates and derived cycle counts
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int RATE_SLOW_PPS = 800;
   localparam int RATE_MID_PPS = 6_400;
   localparam int RATE_FAST_PPS = 12_800;
   localparam logic [15:0] SLOW_CYC = 16'(CLK_HZ / RATE_SLOW_PPS);
   localparam logic [15:0] MID_CYC = 16'(CLK_HZ / RATE_MID_PPS);
   localparam logic [15:0] FAST_CYC = 16'(CLK_HZ / RATE_FAST_PPS);

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [RC_W-1:0] RC_RST = 16'h0000;
   localparam logic [15:0] DIV_RST = 16'h0000;
   localparam logic [ERR_W-1:0] ERR_RST = 15'h0000;

   // Error magnitude band reported by the analog detector
   typedef enum logic [1:0] {RATE_SLOW, RATE_MID, RATE_FAST} gacc_rate_type;

   // Error detector sense lines of one channel
   typedef struct packed {
      logic count_down;
      logic nulled;
      gacc_rate_type band;
   } gacc_sense_type;

   // Ladder decoder drive of one channel, magnitude plus sign
   typedef struct packed {
      logic negative;
      logic [ERR_W-2:0] magnitude;
   } gacc_ladder_type;
endpackage : gacc_pkg

// ---- test/gacc_computer_model.sv ----
// Guidance computer stand-in: sums angle pulses and issues command pulses
`timescale 1ns/1ps
module gacc_computer_model #(
   parameter int N = gacc_pkg::NUM_CH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic counter_zero_cmd,
   input wire logic [N-1:0] ang_inc,
   input wire logic [N-1:0] ang_dec,
   output logic [N-1:0] cmd_plus,
   output logic [N-1:0] cmd_minus
);
   int angle [N];
   initial begin
      cmd_plus = '0;
      cmd_minus = '0;
   end
   // Angle registers: up-pulses added, down-pulses taken off; zero clears them
   always @(posedge clk) begin
      for (int c = 0; c < N; c++) begin
         if (rst || counter_zero_cmd) angle[c] <= 0;
         else angle[c] <= angle[c] + int'(ang_inc[c]) - int'(ang_dec[c]);
      end
   end
   // Strobes set just after an edge and held one cycle; they stand until the next send
   task automatic send(input logic [N-1:0] up, input logic [N-1:0] dn);
      cmd_plus = up;
      cmd_minus = dn;
      @(posedge clk);
      #1;
   endtask : send
endmodule : gacc_computer_model

// ---- test/gimbal_angle_counter_conversion_tb.sv ----
// Self-checking bench: reference model of counters, pulses and ladder drive
`timescale 1ns/1ps
module gimbal_angle_counter_conversion_tb;
   localparam int N = gacc_pkg::NUM_CH;
   logic clk = 0;
   logic rst = 1;
   logic zero = 1;
   logic en = 0;
   logic coarse = 0;
   logic zq, enq, coq;
   gacc_pkg::gacc_sense_type [N-1:0] sense = '0;
   gacc_pkg::gacc_sense_type [N-1:0] sq;
   logic [N-1:0] cp, cm, cpq, cmq, inc, dec;
   logic [N-1:0][15:0] rc;
   logic [N-1:0][6:0] cs;
   logic [N-1:0][10:0] fs;
   gacc_pkg::gacc_ladder_type [N-1:0] lad;
   logic [15:0] rc_q [N];
   logic [15:0] dlt;
   logic [15:0] lfsr = 16'h0053;
   int err [N];
   int steps [N];
   int e0;
   int sage = 0;
   int fails = 0;
   int cmp_count = 0;
   // Short periods keep the run brief; expectations use the same figures
   gacc_top #(.SLOW_CYC(16'h0008), .MID_CYC(16'h0004), .FAST_CYC(16'h0002)) dut (
      .clk(clk), .rst(rst), .sense(sense), .counter_zero_cmd(zero), .err_cnt_enable(en),
      .coarse_align(coarse), .cmd_plus(cp), .cmd_minus(cm), .ang_inc_ff(inc),
      .ang_dec_ff(dec), .read_count_ff(rc), .coarse_sel_ff(cs), .fine_sel_ff(fs),
      .ladder_ff(lad));
   gacc_computer_model #(.N(N)) comp (.clk(clk), .rst(rst), .counter_zero_cmd(zero),
      .ang_inc(inc), .ang_dec(dec), .cmd_plus(cp), .cmd_minus(cm));
   function automatic logic [15:0] nxt_rand(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nxt_rand
   function automatic int period(input gacc_pkg::gacc_rate_type b);
      return b == gacc_pkg::RATE_SLOW ? 8 : b == gacc_pkg::RATE_MID ? 4 : 2;
   endfunction : period
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   initial begin
      forever #12.5 clk = ~clk;
   end
   // Run is some 350 cycles, so 2000 cycles means a hang
   initial begin
      #50000;
      fails++;
      complete_run();
   end
   // Reference model at the falling edge, where every output has settled
   always @(negedge clk) begin
      for (int c = 0; c < N; c++) begin
         dlt = rc[c] - rc_q[c];
         e0 = err[c];
         if (rst) begin
            err[c] = 0;
         end else begin
            if (zq) check(rc[c], 16'h0000, "zeroed");
            else if (sage > 3 && sq[c].nulled) check(dlt, 16'h0000, "nulled hold");
            else if (sage > 3 && dlt != 0)
               check(dlt, {{15{sq[c].count_down}}, 1'b1}, "step");
            if (dlt != 0) steps[c]++;
            check(inc[c], !zq && dlt == 16'h0001 && rc_q[c][0], "inc");
            check(dec[c], !zq && dlt == 16'hFFFF && !rc_q[c][0], "dec");
            check(cs[c], rc[c][15:9], "coarse sel");
            check(fs[c], rc[c][10:0], "fine sel");
            if (enq && cpq[c] != cmq[c]) err[c] += cpq[c] ? 1 : -1;
            if (enq && coq && c < 3 && !zq && dlt != 0 && rc[c][2] != rc_q[c][2] && e0 != 0)
               err[c] += e0 > 0 ? -1 : 1;
            check(lad[c].negative, err[c] < 0, "sign");
            check(lad[c].magnitude, 14'(err[c] < 0 ? -err[c] : err[c]), "size");
         end
         rc_q[c] = rc[c];
      end
      sage = sense == sq ? sage + 1 : 0;
      sq = sense;
      zq = zero;
      enq = en;
      coq = coarse;
      cpq = cp;
      cmq = cm;
   end
   // Main sequence: zero hold, rates, null, wrap, commands, alignment pull
   initial begin
      cyc(8);
      rst = 0;
      cyc(20);
      lfsr = nxt_rand(lfsr);
      for (int c = 0; c < N; c++) begin
         sense[c].band = gacc_pkg::gacc_rate_type'(2'(c) ^ lfsr[1:0]);
      end
      zero = 0;
      cyc(8);
      steps = '{default: 0};
      cyc(48);
      for (int c = 0; c < N; c++) begin
         check(16'(steps[c]), 16'(48 / period(sense[c].band)), "rate");
         sense[c].nulled = 1;
      end
      cyc(20);
      for (int c = 0; c < N; c++) begin
         check(16'(comp.angle[c]), rc[c] >> 1, "angle sum");
         sense[c].nulled = 0;
         sense[c].count_down = 1;
      end
      cyc(8);
      steps = '{default: 0};
      cyc(72); // Resume after null and run below zero, so a stuck or saturating counter shows
      for (int c = 0; c < N; c++) begin
         check(16'(steps[c]), 16'(72 / period(sense[c].band)), "resume");
      end
      en = 1;
      repeat (40) begin
         lfsr = nxt_rand(lfsr);
         comp.send(lfsr[4:0], lfsr[9:5]);
      end
      en = 0;
      repeat (10) comp.send('1, '0); // Disabled: value must hold
      en = 1;
      repeat (12) comp.send('1, '0);
      repeat (4) comp.send('0, 5'b01010); // Counted back down
      en = 0;
      coarse = 1;
      comp.send('0, '0);
      for (int c = 0; c < N; c++) begin
         sense[c].count_down = 0;
      end
      cyc(30); // Alignment alone must not pull
      en = 1;
      cyc(60); // Third stage pulls error toward zero
      en = 0;
      coarse = 0;
      cyc(4);
      complete_run();
   end
endmodule : gimbal_angle_counter_conversion_tb
